/* File: logic/rtcwd_pkg.sv */
/*
   Constants, register map and pin bundle of the timekeeper with alarm and watchdog.
   Assumes a single 100 MHz core clock that also stands in for the timekeeping oscillator.
*/
package rtcwd_pkg;

   // ==============================================================
   // register offsets
   localparam logic [5:0] ADR_HUND     = 6'h00;
   localparam logic [5:0] ADR_SEC      = 6'h01;
   localparam logic [5:0] ADR_MIN      = 6'h02;
   localparam logic [5:0] ADR_MIN_ALM  = 6'h03;
   localparam logic [5:0] ADR_HOUR     = 6'h04;
   localparam logic [5:0] ADR_HOUR_ALM = 6'h05;
   localparam logic [5:0] ADR_DAY      = 6'h06;
   localparam logic [5:0] ADR_DAY_ALM  = 6'h07;
   localparam logic [5:0] ADR_DATE     = 6'h08;
   localparam logic [5:0] ADR_MON      = 6'h09;
   localparam logic [5:0] ADR_YEAR     = 6'h0A;
   localparam logic [5:0] ADR_CMD      = 6'h0B;
   localparam logic [5:0] ADR_WD_LO    = 6'h0C;
   localparam logic [5:0] ADR_WD_HI    = 6'h0D;

   // ==============================================================
   // field positions
   localparam int MON_OSC_STOP_BIT = 7;
   localparam int MON_SQW_OFF_BIT  = 6;
   localparam int HOUR_12H_BIT     = 6;
   localparam int ALM_MASK_BIT     = 7;
   localparam int CMD_TDF_BIT      = 0;
   localparam int CMD_WAF_BIT      = 1;
   localparam int CMD_TDM_BIT      = 2;
   localparam int CMD_WAM_BIT      = 3;
   localparam int CMD_PULSE_BIT    = 4;
   localparam int CMD_POLB_BIT     = 5;
   localparam int CMD_ROUTE_BIT    = 6;
   localparam int CMD_TE_BIT       = 7;

   // ==============================================================
   // writable bits per register and reset values
   localparam logic [7:0] WMASK_SEC     = 8'h7F;
   localparam logic [7:0] WMASK_DAY     = 8'h07;
   localparam logic [7:0] WMASK_DATE    = 8'h3F;
   localparam logic [7:0] WMASK_MON     = 8'hDF;
   localparam logic [7:0] WMASK_DAY_ALM = 8'h87;
   localparam logic [7:0] WMASK_CMD     = 8'hFC;
   localparam logic [7:0] RST_MON       = 8'hC1;
   localparam logic [7:0] RST_ONE       = 8'h01;
   localparam logic [7:0] RST_CMD       = 8'h8C;

   // ==============================================================
   // timing
   localparam int unsigned CLK_PERIOD_NS  = 10;
   localparam int unsigned TICK_PERIOD_NS = 10_000_000;
   localparam int unsigned SQW_FREQ_HZ    = 1024;
   localparam int unsigned PULSE_MIN_MS   = 3;
   localparam int unsigned TICK_CYC       = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int unsigned SQW_HALF_CYC   = 1_000_000_000 / (2 * SQW_FREQ_HZ * CLK_PERIOD_NS);
   localparam int unsigned PULSE_CYC      = (PULSE_MIN_MS * 1_000_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==============================================================
   // host bus pins as sampled
   typedef struct packed {
      logic       ce_n;
      logic       oe_n;
      logic       we_n;
      logic [5:0] addr_lines;
      logic [7:0] data_lines;
   } rtcwd_bus_type;

   localparam rtcwd_bus_type BUS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr_lines: 6'h00, data_lines: 8'h00};

endpackage

/* File: logic/rtcwd_top.sv */
/*
   Timekeeper core: BCD clock/calendar, time-of-day alarm, BCD watchdog, interrupt shaping,
   square-wave output and a 64-byte register file behind an asynchronous SRAM-style bus.
   Assumes bus pins arrive asynchronously and the host holds each strobe level for well over
   three core clocks; the wire levels of the three-state pins are resolved outside.
*/
// Summary of operation
// R1: unused time bits read zero
// R2: months bit 7 stops oscillator
// R3: months bit 6 gates 1024 Hz output
// R4: hours bit 6 selects 12-hour format
// R5: refresh external time unless frozen or stopped
// R6: internal time keeps counting while frozen
// R7: increment at 99, copy at rollover
// R8: alarm mask bits select match fields
// R9: all masks: alarm each minute rollover
// R10: alarm register access clears alarm flag
// R11: watchdog reload is four BCD digits
// R12: watchdog access reloads and clears flag
// R13: expiry flags and reloads, repeating
// R14: watchdog reads return stored value
// R15: all-zero reload disables watchdog
// R16: alarm flag read-only, set by hardware
// R17: watchdog flag read-only, set by hardware
// R18: command bit 2 masks alarm output
// R19: command bit 3 masks watchdog output
// R20: command bit 4 selects 3 ms pulses
// R21: command bit 5 sets output B polarity
// R22: command bit 6 swaps output routing
// R23: read while chip and output strobes low
// R24: write spans both strobes low
// R25: upper bytes are plain storage
// R26: level mode follows unmasked flag
module rtcwd_top
   import rtcwd_pkg::*;
#(
   parameter int unsigned TICK_CYCLES  = TICK_CYC,
   parameter int unsigned SQW_CYCLES   = SQW_HALF_CYC,
   parameter int unsigned PULSE_CYCLES = PULSE_CYC
)
(
   input  wire logic          core_clk,
   input  wire logic          rst_n,
   input  wire rtcwd_bus_type bus_pins,
   output logic [7:0]         data_lines_o,
   output logic               data_lines_oe,
   output logic               irq_out_a_o,
   output logic               irq_out_a_oe,
   output logic               irq_out_b_o,
   output logic               irq_out_b_oe,
   output logic               square_wave_out_o,
   output logic               square_wave_out_oe
);

   localparam int TW = $clog2(TICK_CYCLES) + 1;
   localparam int SW = $clog2(SQW_CYCLES) + 1;
   localparam int PW = $clog2(PULSE_CYCLES) + 1;

   // ==============================================================
   // helpers
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
   endfunction

   function automatic logic [15:0] bcd_dec(input logic [15:0] v);
      logic [15:0] r;
      logic        borrow;
      r      = v;
      borrow = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         if (borrow)
         begin
            if (r[4*i +: 4] == 4'h0)
               r[4*i +: 4] = 4'h9;
            else
            begin
               r[4*i +: 4] = r[4*i +: 4] - 4'h1;
               borrow      = 1'b0;
            end
         end
      end
      bcd_dec = r;
   endfunction

   function automatic logic [7:0] hour_inc(input logic [7:0] h);
      logic [7:0] t;
      t = 8'h00;
      if (h[HOUR_12H_BIT])
      begin
         t = bcd_inc({3'h0, h[4:0]});
         if (h[4:0] == 5'h11)
            hour_inc = {h[7:6], ~h[5], 5'h12};
         else if (h[4:0] == 5'h12)
            hour_inc = {h[7:5], 5'h01};
         else
            hour_inc = {h[7:5], t[4:0]};
      end
      else
      begin
         t = bcd_inc({2'h0, h[5:0]});
         hour_inc = (h[5:0] == 6'h23) ? {h[7:6], 6'h00} : {h[7:6], t[5:0]};
      end
   endfunction

   function automatic logic [7:0] month_days(input logic [7:0] mon, input logic [7:0] yr);
      logic leap;
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                   : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
      case (mon[4:0])
         5'h02:                      month_days = leap ? 8'h29 : 8'h28;
         5'h04, 5'h06, 5'h09, 5'h11: month_days = 8'h30;
         default:                    month_days = 8'h31;
      endcase
   endfunction

   function automatic logic [7:0] wmask(input logic [5:0] a);
      case (a)
         ADR_SEC, ADR_MIN, ADR_HOUR: wmask = WMASK_SEC;
         ADR_DAY:                    wmask = WMASK_DAY;
         ADR_DATE:                   wmask = WMASK_DATE;
         ADR_MON:                    wmask = WMASK_MON;
         ADR_DAY_ALM:                wmask = WMASK_DAY_ALM;
         ADR_CMD:                    wmask = WMASK_CMD;
         default:                    wmask = 8'hFF;
      endcase
   endfunction

   // ==============================================================
   // bus pins: two-stage synchroniser, strobe decode
   rtcwd_bus_type s1_q;
   rtcwd_bus_type s2_q;
   logic          wr_act_q;
   logic          rd_oe_q;
   logic [5:0]    wa_q;
   logic [7:0]    wdat_q;
   logic [7:0]    rdata_q;
   logic [7:0]    mem_q [64];

   // R24: write window
   wire        wr_act    = !s2_q.ce_n && !s2_q.we_n;
   // R23: read window
   wire        rd_act    = !s2_q.ce_n && !s2_q.oe_n && s2_q.we_n;
   wire        wr_commit = wr_act_q && !wr_act;
   wire        rd_start  = rd_act && !rd_oe_q;
   wire        acc_stb   = wr_commit || rd_start;
   wire [5:0]  acc_addr  = wr_commit ? wa_q : s2_q.addr_lines;
   // R1: unused bits never stored
   wire [7:0]  wr_val    = wdat_q & wmask(wa_q);
   // R10: any alarm register access
   wire        tod_clr   = acc_stb && (acc_addr == ADR_MIN_ALM || acc_addr == ADR_HOUR_ALM
                                       || acc_addr == ADR_DAY_ALM);
   // R12: any watchdog register access
   wire        wd_acc    = acc_stb && (acc_addr == ADR_WD_LO || acc_addr == ADR_WD_HI);
   wire [7:0]  cmd       = mem_q[ADR_CMD];
   wire        te        = cmd[CMD_TE_BIT];

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_q     <= BUS_IDLE;
         s2_q     <= BUS_IDLE;
         wr_act_q <= 1'b0;
         rd_oe_q  <= 1'b0;
         wa_q     <= 6'h00;
         wdat_q   <= 8'h00;
      end
      else
      begin
         s1_q     <= bus_pins;
         s2_q     <= s1_q;
         wr_act_q <= wr_act;
         rd_oe_q  <= rd_act;
         if (wr_act)
         begin
            wa_q   <= s2_q.addr_lines;
            wdat_q <= s2_q.data_lines;
         end
      end
   end

   // ==============================================================
   // hundredths tick from the oscillator
   logic [TW-1:0] tick_cnt_q;
   // R2: stop bit halts all timekeeping
   wire osc_run = !mem_q[ADR_MON][MON_OSC_STOP_BIT];
   wire tick    = osc_run && (tick_cnt_q == TW'(TICK_CYCLES - 1));

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         tick_cnt_q <= '0;
      else if (osc_run)
         tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
   end

   // ==============================================================
   // internal time copy
   logic [7:0] hund_q, sec_q, min_q, hour_q, day_q, date_q, mon_q, year_q;

   // R7: carry work on the tick that takes hundredths from 98 to 99
   wire carry_step = tick && (hund_q == 8'h98);
   wire roll       = tick && (hund_q == 8'h99);
   wire sec_w      = (sec_q == 8'h59);
   wire min_w      = (min_q == 8'h59);
   // R4: 11 PM or 23 wraps the day
   wire hr_w       = hour_q[HOUR_12H_BIT] ? (hour_q[5:0] == 6'h31) : (hour_q[5:0] == 6'h23);
   wire date_w     = (date_q == month_days(mon_q, year_q));
   wire c_hr       = sec_w && min_w;
   wire c_day      = c_hr && hr_w;
   wire c_mon      = c_day && date_w;
   // alarm bytes sit inside the time range but must not steal a tick
   wire time_wr    = wr_commit && (wa_q <= ADR_YEAR) && (wa_q != ADR_MIN_ALM)
                     && (wa_q != ADR_HOUR_ALM) && (wa_q != ADR_DAY_ALM);
   wire [7:0] hund_n = roll ? 8'h00 : bcd_inc(hund_q);
   wire [7:0] sec_n  = sec_w ? 8'h00 : bcd_inc(sec_q);
   wire [7:0] min_n  = sec_w ? (min_w ? 8'h00 : bcd_inc(min_q)) : min_q;
   wire [7:0] hour_n = c_hr ? hour_inc(hour_q) : hour_q;
   wire [7:0] day_n  = c_day ? ((day_q == 8'h07) ? 8'h01 : bcd_inc(day_q)) : day_q;
   wire [7:0] date_n = c_day ? (date_w ? 8'h01 : bcd_inc(date_q)) : date_q;
   wire [7:0] mon_n  = c_mon ? ((mon_q == 8'h12) ? 8'h01 : bcd_inc(mon_q)) : mon_q;
   wire [7:0] year_n = (c_mon && mon_q == 8'h12) ? ((year_q == 8'h99) ? 8'h00 : bcd_inc(year_q)) : year_q;

   // R6: counts on regardless of the transfer bit
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         {hund_q, sec_q, min_q, hour_q, year_q} <= '0;
         day_q  <= RST_ONE;
         date_q <= RST_ONE;
         mon_q  <= RST_ONE;
      end
      else if (time_wr)
      begin
         case (wa_q)
            ADR_HUND: hund_q <= wr_val;
            ADR_SEC:  sec_q  <= wr_val;
            ADR_MIN:  min_q  <= wr_val;
            ADR_HOUR: hour_q <= wr_val;
            ADR_DAY:  day_q  <= wr_val;
            ADR_DATE: date_q <= wr_val;
            ADR_MON:  mon_q  <= {3'h0, wr_val[4:0]};
            ADR_YEAR: year_q <= wr_val;
            default:  hund_q <= hund_q;
         endcase
      end
      else if (tick)
      begin
         hund_q <= hund_n;
         if (carry_step)
         begin
            {sec_q, min_q, hour_q, day_q} <= {sec_n, min_n, hour_n, day_n};
            {date_q, mon_q, year_q}       <= {date_n, mon_n, year_n};
         end
      end
   end

   // ==============================================================
   // time-of-day alarm
   logic tdf_q;
   wire [7:0] a_min  = mem_q[ADR_MIN_ALM];
   wire [7:0] a_hour = mem_q[ADR_HOUR_ALM];
   wire [7:0] a_day  = mem_q[ADR_DAY_ALM];
   // R8: masked fields always match
   wire match   = (a_min[ALM_MASK_BIT] || a_min[6:0] == min_n[6:0])
                  && (a_hour[ALM_MASK_BIT] || a_hour[6:0] == hour_n[6:0])
                  && (a_day[ALM_MASK_BIT] || a_day[2:0] == day_n[2:0]);
   // R9: checked only at the seconds rollover
   wire alm_hit = carry_step && sec_w && match;

   // R16: set wins over the access clear
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         tdf_q <= 1'b0;
      else if (alm_hit)
         tdf_q <= 1'b1;
      else if (tod_clr)
         tdf_q <= 1'b0;
   end

   // ==============================================================
   // watchdog
   logic [15:0] wd_cnt_q;
   logic        wd_load_q;
   logic        waf_q;
   // R11: reload value in hundredths, BCD
   wire [15:0] wd_rel    = {mem_q[ADR_WD_HI], mem_q[ADR_WD_LO]};
   // R15: zero reload disables it
   wire        wd_on     = (wd_rel != 16'h0000);
   // R13: reaching zero raises the alarm
   wire        wd_expire = tick && wd_on && !wd_load_q && (wd_cnt_q <= 16'h0001);

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wd_cnt_q  <= 16'h0000;
         wd_load_q <= 1'b0;
         waf_q     <= 1'b0;
      end
      else
      begin
         wd_load_q <= wd_acc;
         // R12: reload one cycle after the access lands
         if (wd_load_q || wd_expire)
            wd_cnt_q <= wd_rel;
         else if (tick && wd_on)
            wd_cnt_q <= bcd_dec(wd_cnt_q);
         // R17: set wins over the access clear
         if (wd_expire)
            waf_q <= 1'b1;
         else if (wd_acc)
            waf_q <= 1'b0;
      end
   end

   // ==============================================================
   // register file
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < 64; i++)
            mem_q[i] <= 8'h00;
         mem_q[ADR_DAY]  <= RST_ONE;
         mem_q[ADR_DATE] <= RST_ONE;
         mem_q[ADR_MON]  <= RST_MON;
         mem_q[ADR_CMD]  <= RST_CMD;
      end
      else
      begin
         // R5: frozen while the transfer bit is clear
         if (tick && te)
            mem_q[ADR_HUND] <= hund_n;
         // R7: seconds up copied at the 99 to 00 roll
         if (roll && te)
         begin
            {mem_q[ADR_SEC], mem_q[ADR_MIN], mem_q[ADR_HOUR]} <= {sec_q, min_q, hour_q};
            {mem_q[ADR_DAY], mem_q[ADR_DATE], mem_q[ADR_YEAR]} <= {day_q, date_q, year_q};
            mem_q[ADR_MON] <= {mem_q[ADR_MON][7:6], mon_q[5:0]};
         end
         // R25: plain storage beyond the command block
         if (wr_commit)
            mem_q[wa_q] <= wr_val;
      end
   end

   // R14: watchdog reads return stored reload
   wire [7:0] rd_val = (s2_q.addr_lines == ADR_CMD) ? {cmd[7:2], waf_q, tdf_q} : mem_q[s2_q.addr_lines];

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         rdata_q <= 8'h00;
      else
         rdata_q <= rd_val;
   end

   assign data_lines_o  = rdata_q;
   assign data_lines_oe = rd_oe_q;

   // ==============================================================
   // interrupt shaping and routing
   logic [PW-1:0] pc_tod_q, pc_wd_q;
   logic          irq_a_q, irq_b_q, irq_b_lvl_q;
   // R20: pulse of fixed minimum length per event
   wire tod_src = cmd[CMD_PULSE_BIT] ? (pc_tod_q != '0) : tdf_q;
   // R26: level mode tracks the flag
   wire wd_src  = cmd[CMD_PULSE_BIT] ? (pc_wd_q != '0) : waf_q;
   // R18: alarm output mask
   wire tod_act = tod_src && !cmd[CMD_TDM_BIT];
   // R19: watchdog output mask
   wire wd_act  = wd_src && !cmd[CMD_WAM_BIT];

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pc_tod_q    <= '0;
         pc_wd_q     <= '0;
         irq_a_q     <= 1'b0;
         irq_b_q     <= 1'b0;
         irq_b_lvl_q <= 1'b0;
      end
      else
      begin
         pc_tod_q    <= alm_hit ? PW'(PULSE_CYCLES) : (pc_tod_q != '0) ? pc_tod_q - 1'b1 : '0;
         pc_wd_q     <= wd_expire ? PW'(PULSE_CYCLES) : (pc_wd_q != '0) ? pc_wd_q - 1'b1 : '0;
         // R22: swap applies even to an active output
         irq_a_q     <= cmd[CMD_ROUTE_BIT] ? tod_act : wd_act;
         irq_b_q     <= cmd[CMD_ROUTE_BIT] ? wd_act : tod_act;
         // R21: output B drive level
         irq_b_lvl_q <= cmd[CMD_POLB_BIT];
      end
   end

   assign irq_out_a_o  = 1'b0;
   assign irq_out_a_oe = irq_a_q;
   assign irq_out_b_o  = irq_b_lvl_q;
   assign irq_out_b_oe = irq_b_q;

   // ==============================================================
   // square wave
   logic [SW-1:0] sqw_cnt_q;
   logic          sqw_q, sqw_oe_q;
   wire sqw_flip = osc_run && (sqw_cnt_q == SW'(SQW_CYCLES - 1));

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sqw_cnt_q <= '0;
         sqw_q     <= 1'b0;
         sqw_oe_q  <= 1'b0;
      end
      else
      begin
         if (osc_run)
            sqw_cnt_q <= sqw_flip ? '0 : sqw_cnt_q + 1'b1;
         sqw_q    <= sqw_q ^ sqw_flip;
         // R3: bit clear drives the pin, set floats it
         sqw_oe_q <= !mem_q[ADR_MON][MON_SQW_OFF_BIT];
      end
   end

   assign square_wave_out_o  = sqw_q;
   assign square_wave_out_oe = sqw_oe_q;

   // ==============================================================
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_copy_roll;
      roll && te && !wr_commit;
   endsequence
   sequence s_minute_all_masked;
      carry_step && sec_w && a_min[7] && a_hour[7] && a_day[7];
   endsequence

   property p_osc_stop;
      !osc_run && !wr_commit && !wd_load_q |=> $stable(hund_q) && $stable(wd_cnt_q);
   endproperty
   property p_sqw_oe;
      $changed(mem_q[ADR_MON][MON_SQW_OFF_BIT]) |=> square_wave_out_oe == !$past(mem_q[ADR_MON][MON_SQW_OFF_BIT]);
   endproperty
   property p_freeze;
      tick && !te && !wr_commit |=> $stable(mem_q[ADR_HUND]);
   endproperty
   property p_copy;
      s_copy_roll |=> mem_q[ADR_SEC] == sec_q && mem_q[ADR_YEAR] == year_q;
   endproperty
   property p_minute;
      s_minute_all_masked |=> tdf_q ##0 (pc_tod_q == PW'(PULSE_CYCLES));
   endproperty
   property p_tod_clr;
      tod_clr && !alm_hit |=> !tdf_q;
   endproperty
   property p_wd_clr;
      wd_acc && !wd_expire |=> !waf_q ##1 wd_cnt_q == $past(wd_rel);
   endproperty
   property p_wd_off;
      !wd_on && !waf_q |=> !waf_q;
   endproperty
   property p_tdm;
      cmd[CMD_TDM_BIT] && cmd[CMD_WAM_BIT] |=> !irq_out_a_oe && !irq_out_b_oe;
   endproperty
   property p_route;
      ##1 irq_out_a_oe == ($past(cmd[CMD_ROUTE_BIT]) ? $past(tod_act) : $past(wd_act));
   endproperty
   property p_pulse;
      $rose(pc_wd_q != '0) |-> (pc_wd_q != '0)[*8];
   endproperty

   a_osc_stop: assert property (p_osc_stop) else $error("tick while oscillator stopped"); // R2
   a_sqw_oe: assert property (p_sqw_oe) else $error("square wave enable wrong"); // R3
   a_freeze: assert property (p_freeze) else $error("hundredths changed while frozen"); // R5
   a_copy: assert property (p_copy) else $error("time not copied at rollover"); // R7
   a_minute: assert property (p_minute) else $error("per-minute alarm missing"); // R9
   a_tod_clr: assert property (p_tod_clr) else $error("alarm flag not cleared"); // R10
   a_wd_clr: assert property (p_wd_clr) else $error("watchdog not reloaded"); // R12
   a_wd_off: assert property (p_wd_off) else $error("disabled watchdog expired"); // R15
   a_tdm: assert property (p_tdm) else $error("masked interrupt driven"); // R18
   a_route: assert property (p_route) else $error("output A routing wrong"); // R22
   a_pulse: assert property (p_pulse) else $error("pulse too short"); // R20

endmodule

/* File: bench/rtcwd_host.sv */
/*
   Host processor model for the SRAM-style bus of the timekeeper.
   Assumes one task call at a time; strobes move on the falling clock edge.
*/
module rtcwd_host
   import rtcwd_pkg::*;
(
   input  wire logic       core_clk,
   output rtcwd_bus_type   bus_pins,
   input  wire logic [7:0] data_lines_o,
   input  wire logic       data_lines_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   rtcwd_bus_type pins_q = BUS_IDLE;
   // ==============================================================
   // wire level: a released data wire shows the inverse of the last byte the host wrote
   assign bus_pins = {pins_q[16:8], (data_lines_oe ? data_lines_o : pins_q.data_lines)};
   // ==============================================================
   // bus cycles
   // hold address through write
   task automatic bus_write(input logic [5:0] addr, input logic [7:0] data);
      @(negedge core_clk);
      pins_q = '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b0, addr_lines: addr, data_lines: data};
      repeat (5) @(negedge core_clk);
      pins_q.ce_n = 1'b1;
      pins_q.we_n = 1'b1;
      repeat (4) @(negedge core_clk);
      pins_q.data_lines = ~data;
   endtask
   // read window, take data at edge
   task automatic bus_read(input logic [5:0] addr, output logic [7:0] data);
      data = 'x;
      @(negedge core_clk);
      pins_q.ce_n = 1'b0;
      pins_q.oe_n = 1'b0;
      pins_q.addr_lines = addr;
      for (int i = 0; i < 10; i++)
      begin
         @(negedge core_clk);
         if (data_lines_oe === 1'b1)
         begin
            data = data_lines_o;
            break;
         end
      end
      @(negedge core_clk);
      pins_q.ce_n = 1'b1;
      pins_q.oe_n = 1'b1;
      repeat (4) @(negedge core_clk);
   endtask
endmodule

/* File: bench/tb_top.sv */
/*
   Self-checking bench: register map, masks, watchdog and alarm interrupts.
   Assumes shortened tick, square-wave and pulse counts; bus cycles come from the host model.
*/
module tb_top
   import rtcwd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic          core_clk = 1'b0;
   logic          rst_n = 1'b0;
   rtcwd_bus_type bus_pins;
   logic [7:0]    data_lines_o;
   logic          data_lines_oe;
   logic          irq_a_oe;
   logic          irq_a_o;
   logic          sqw_o;
   logic          irq_b_o;
   logic          irq_b_oe;
   logic          sqw_oe;
   int            bad_count = 0;
   int            tests_run = 0;
   int            cycle_count = 0;
   always #5 core_clk = ~core_clk;
   rtcwd_top #(.TICK_CYCLES(20), .SQW_CYCLES(4), .PULSE_CYCLES(10)) rtcwd_top_inst (
      .core_clk(core_clk), .rst_n(rst_n), .bus_pins(bus_pins), .data_lines_o(data_lines_o),
      .data_lines_oe(data_lines_oe), .irq_out_a_o(irq_a_o), .irq_out_a_oe(irq_a_oe), .irq_out_b_o(irq_b_o),
      .irq_out_b_oe(irq_b_oe), .square_wave_out_o(sqw_o), .square_wave_out_oe(sqw_oe));
   rtcwd_host rtcwd_host_inst (.core_clk(core_clk), .bus_pins(bus_pins), .data_lines_o(data_lines_o),
      .data_lines_oe(data_lines_oe));
   // ==============================================================
   // helpers
   task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic check_pin(input string name, input logic exp, input logic got);
      check_byte(name, {7'h00, exp}, {7'h00, got});
   endtask
   task automatic wr(input logic [5:0] addr, input logic [7:0] data);
      rtcwd_host_inst.bus_write(addr, data);
   endtask
   task automatic rd_check(input logic [5:0] addr, input logic [7:0] exp, input string name);
      logic [7:0] got;
      rtcwd_host_inst.bus_read(addr, got);
      check_byte(name, exp, got);
   endtask
   task automatic wait_irq_a(input int limit);
      for (int i = 0; i < limit && irq_a_oe !== 1'b1; i++)
         @(negedge core_clk);
      @(negedge core_clk);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // a hang counts as a mismatch
   always @(posedge core_clk)
   begin
      cycle_count++;
      if (cycle_count == 12000)
      begin
         bad_count++;
         complete_run();
      end
   end
   // ==============================================================
   // main sequence
   initial
   begin
      logic       sqw_seen;
      logic [7:0] hund_seen;
      repeat (20) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (100) @(negedge core_clk);
      rd_check(ADR_CMD, RST_CMD, "command");
      rd_check(ADR_MON, RST_MON, "months");
      rd_check(ADR_DAY, RST_ONE, "day");
      rd_check(ADR_HUND, 8'h00, "hundredths while stopped");
      wr(ADR_SEC, 8'hFF);
      rd_check(ADR_SEC, WMASK_SEC, "seconds unused bits");
      wr(ADR_DAY_ALM, 8'hFF);
      rd_check(ADR_DAY_ALM, WMASK_DAY_ALM, "day alarm unused bits");
      wr(6'h3F, 8'hA5);
      rd_check(6'h3F, 8'hA5, "storage byte");
      wr(ADR_CMD, 8'h8F);
      rd_check(ADR_CMD, 8'h8C, "command flags read only");
      check_pin("square wave enable off", 1'b0, sqw_oe);
      wr(ADR_MON, 8'h01);
      check_pin("square wave enable on", 1'b1, sqw_oe);
      sqw_seen = sqw_o;
      repeat (4) @(negedge core_clk);
      check_pin("square wave half period", ~sqw_seen, sqw_o);
      // watchdog on A, level mode, 10 ticks
      wr(ADR_WD_HI, 8'h00);
      wr(ADR_WD_LO, 8'h10);
      wr(ADR_CMD, 8'h84);
      wait_irq_a(600);
      check_pin("watchdog on A", 1'b1, irq_a_oe);
      rd_check(ADR_CMD, 8'h86, "watchdog flag");
      rd_check(ADR_WD_LO, 8'h10, "reload value");
      check_pin("watchdog cleared", 1'b0, irq_a_oe);
      rd_check(ADR_CMD, 8'h84, "watchdog flag cleared");
      // pulse mode releases while the flag stays set
      wr(ADR_CMD, 8'h94);
      wait_irq_a(600);
      check_pin("pulse start", 1'b1, irq_a_oe);
      repeat (12) @(negedge core_clk);
      check_pin("pulse released", 1'b0, irq_a_oe);
      rd_check(ADR_CMD, 8'h96, "flag after pulse");
      // alarm every minute on A, watchdog disabled on B
      wr(ADR_WD_LO, 8'h00);
      wr(ADR_MIN_ALM, 8'h80);
      wr(ADR_HOUR_ALM, 8'h80);
      wr(ADR_DAY_ALM, 8'h80);
      wr(ADR_SEC, 8'h59);
      wr(ADR_CMD, 8'hC0);
      wait_irq_a(2600);
      check_pin("minute alarm on A", 1'b1, irq_a_oe);
      check_pin("disabled watchdog on B", 1'b0, irq_b_oe);
      check_pin("B drive level", 1'b0, irq_b_o);
      rd_check(ADR_CMD, 8'hC1, "alarm flag");
      rd_check(ADR_MIN_ALM, 8'h80, "minutes alarm");
      check_pin("alarm cleared", 1'b0, irq_a_oe);
      check_pin("output A level", 1'b0, irq_a_o);
      // transfer off freezes the visible time; B switched to drive high
      wr(ADR_CMD, 8'h2C);
      check_pin("B drive high", 1'b1, irq_b_o);
      rtcwd_host_inst.bus_read(ADR_HUND, hund_seen);
      repeat (60) @(negedge core_clk);
      rd_check(ADR_HUND, hund_seen, "hundredths frozen");
      complete_run();
   end
endmodule
